// ==== common/i2c_poller_pkg.sv ====
// package for the i2c sensor poller: slave addresses, pointers,
// scale steps, calibration, timing counts and shared types.
// assumes a 200 MHz system clock and a shared open-drain i2c bus.
`default_nettype none
package i2c_poller_pkg;
	// clock and i2c bit timing (100 kHz, four quarters per bit)
	localparam int CLOCK_NS       = 5;
	localparam int I2C_QUARTER_NS = 2500;
	localparam int QUARTER_CYC    =
		(I2C_QUARTER_NS + CLOCK_NS - 1) / CLOCK_NS;
	localparam logic [9:0] QUARTER_LAST = 10'(QUARTER_CYC - 1);
	// 8-bit slave address bytes (read/write bit is bit 0)
	localparam logic [7:0] HUMID_ADDR = 8'h80;
	localparam logic [7:0] POWER_ADDR = 8'h80;
	localparam logic [7:0] PROX_ADDR  = 8'hB4;
	localparam logic [7:0] RD_BIT     = 8'h01;
	// sensor register pointers
	localparam logic [7:0] HT_TEMP_REG  = 8'h00;
	localparam logic [7:0] HT_HUM_REG   = 8'h01;
	localparam logic [7:0] PM_SHUNT_REG = 8'h01;
	localparam logic [7:0] PM_BUS_REG   = 8'h02;
	localparam logic [7:0] PM_POWER_REG = 8'h03;
	localparam logic [7:0] PM_CUR_REG   = 8'h04;
	localparam logic [7:0] PM_CAL_REG   = 8'h05;
	localparam logic [7:0] PROX_FIRST   = 8'h26;
	// scale steps: 1.25mV, 2.5uV, 2.5mW per count
	localparam logic [15:0] BUS_UV_PER_LSB   = 16'h04E2;
	localparam logic [15:0] SHUNT_NV_PER_LSB = 16'h09C4;
	localparam logic [15:0] POWER_UW_PER_LSB = 16'h09C4;
	localparam logic [19:0] UW_PER_W_SCALE   = 20'hF4240;
	// temperature: raw / 65536 * 165 - 40
	localparam logic [7:0]  TEMP_SPAN   = 8'hA5;
	localparam logic [8:0]  TEMP_OFFSET = 9'h028;
	// calibration = 0.00512 / (current step * shunt)
	localparam real SHUNT_OHM      = 0.003;
	localparam real MAX_CURRENT_A  = 3.2768;
	localparam real CURRENT_LSB_A  = MAX_CURRENT_A / 32768.0;
	localparam logic [15:0] CAL_VALUE =
		16'($rtoi(0.00512 / (CURRENT_LSB_A * SHUNT_OHM)));
	localparam logic [3:0] SHUNT_MILLIOHM =
		4'($rtoi(SHUNT_OHM * 1000.0 + 0.5));
	// level mapper: indicator i (1..7) lights at LEVEL_BASE << i; indicator 0 is always lit
	localparam logic [15:0] LEVEL_BASE = 16'h0040;
	// polling schedule
	localparam logic [3:0] SLOT_LAST  = 4'hB;
	localparam logic [3:0] SLOT_PROX  = 4'h6;
	typedef enum logic [1:0] {CMD_START, CMD_STOP, CMD_WRITE,
		CMD_READ} i2c_cmd_t;
	typedef struct packed {
		logic [7:0] dev;      // address byte, write form
		logic [7:0] ptr;      // register pointer
		logic       wait_rdy; // poll ready line after pointer
		logic       two_byte; // 16-bit register
	} slot_t;
	// one entry of the round-robin schedule
	function automatic slot_t slot_info(input logic [3:0] idx);
		slot_t r;
		r = '{dev: PROX_ADDR, ptr: PROX_FIRST + 8'(idx - SLOT_PROX),
			wait_rdy: 1'b0, two_byte: 1'b0};
		unique case (idx)
			4'h0: r = '{HUMID_ADDR, HT_TEMP_REG, 1'b1, 1'b1};
			4'h1: r = '{HUMID_ADDR, HT_HUM_REG, 1'b1, 1'b1};
			4'h2: r = '{POWER_ADDR, PM_BUS_REG, 1'b0, 1'b1};
			4'h3: r = '{POWER_ADDR, PM_SHUNT_REG, 1'b0, 1'b1};
			4'h4: r = '{POWER_ADDR, PM_CUR_REG, 1'b0, 1'b1};
			4'h5: r = '{POWER_ADDR, PM_POWER_REG, 1'b0, 1'b1};
			default: ;
		endcase
		return r;
	endfunction : slot_info
endpackage : i2c_poller_pkg
`default_nettype wire

// ==== src/i2c_byte_engine.sv ====
// i2c master byte engine: start, stop, byte write, byte read.
// assumes open-drain pins resolved outside; oe high pulls low.
`default_nettype none
module i2c_byte_engine
	import i2c_poller_pkg::*;
(
	// clock and reset
	input  wire logic       i_clock,
	input  wire logic       i_rstn,
	// command side
	input  wire logic       i_cmd_valid,
	input  var  i2c_cmd_t   i_cmd,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_master_ack,
	output logic            o_done,
	output logic            o_nack,
	output logic [7:0]      o_rdata,
	// bus pins
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	output logic            o_scl_oe,
	output logic            o_sda_oe
);
	typedef struct packed {
		logic       busy;   // command in progress
		i2c_cmd_t   cmd;    // command held
		logic [9:0] div;    // quarter-bit divider
		logic [1:0] q;      // quarter within phase
		logic [3:0] bitn;   // bit count, 9 per byte
		logic [8:0] sh;     // out bits, then sampled bits
		logic       scl_oe; // pull scl low
		logic       sda_oe; // pull sda low
		logic       done;   // one-cycle completion
		logic       nack;   // ack bit seen high
		logic [7:0] rdata;  // byte received
	} eng_t;
	eng_t s_reg, s_next;

	// quarter sequencer; each phase walks q 0..3
	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		if (!s_reg.busy) begin
			if (i_cmd_valid) begin
				s_next.busy = 1'b1;
				s_next.cmd  = i_cmd;
				s_next.div  = '0;
				s_next.q    = '0;
				s_next.bitn = '0;
				// read: release data bits, then our ack
				s_next.sh = (i_cmd == CMD_WRITE) ? {i_wdata, 1'b1}
					: {8'hFF, ~i_master_ack};
			end
		end else if (s_reg.div != QUARTER_LAST) begin
			s_next.div = s_reg.div + 10'h001;
		end else begin
			s_next.div = '0;
			s_next.q   = s_reg.q + 2'h1;
			unique case (s_reg.cmd)
				CMD_START: begin
					// also serves as repeated start from scl low
					case (s_reg.q)
						2'h0: s_next.sda_oe = 1'b0;
						2'h1: s_next.scl_oe = 1'b0;
						2'h2: s_next.sda_oe = 1'b1;
						default: s_next.scl_oe = 1'b1;
					endcase
				end
				CMD_STOP: begin
					case (s_reg.q)
						2'h0: s_next.sda_oe = 1'b1;
						2'h1: s_next.scl_oe = 1'b0;
						2'h2: s_next.sda_oe = 1'b0;
						default: ;
					endcase
				end
				default: begin
					case (s_reg.q)
						2'h0: s_next.sda_oe = ~s_reg.sh[8];
						2'h1: s_next.scl_oe = 1'b0;
						2'h2: begin
							// a slave stretching scl holds us here
							if (!i_scl)
								s_next.q = s_reg.q;
							else
								s_next.sh = {s_reg.sh[7:0], i_sda};
						end
						default: begin
							s_next.scl_oe = 1'b1;
							s_next.bitn = s_reg.bitn + 4'h1;
						end
					endcase
				end
			endcase
			// finish after q3 of a start/stop or the ninth bit
			if (s_reg.q == 2'h3 && (s_reg.cmd == CMD_START ||
				s_reg.cmd == CMD_STOP || s_reg.bitn == 4'h8)) begin
				s_next.busy = 1'b0;
				s_next.done = 1'b1;
				if (s_reg.cmd == CMD_WRITE || s_reg.cmd == CMD_READ) begin
					s_next.sda_oe = 1'b0;
					s_next.nack   = s_reg.sh[0];
					s_next.rdata  = s_reg.sh[8:1];
				end
			end
		end
	end

	// state register
	always_ff @(posedge i_clock) begin
		if (!i_rstn)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign o_done   = s_reg.done;
	assign o_nack   = s_reg.nack;
	assign o_rdata  = s_reg.rdata;
	assign o_scl_oe = s_reg.scl_oe;
	assign o_sda_oe = s_reg.sda_oe;
endmodule : i2c_byte_engine
`default_nettype wire

// ==== src/level_mapper.sv ====
// level mapper: proximity average to an 8-bit thermometer bar.
// assumes a larger proximity count means a nearer object.
`default_nettype none
module level_mapper
	import i2c_poller_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_rstn,
	input  wire logic [15:0] i_avg,
	output logic [7:0]       o_level
);
	typedef struct packed {
		logic [7:0] level; // registered bar
	} map_t;
	map_t s_reg, s_next;
	logic [7:0] lit;

	// the lowest indicator stays lit however far the object is
	assign lit[0] = 1'b1;
	for (genvar i = 1; i < 8; i++) begin : g_step
		// nearer object crosses more doubling thresholds
		assign lit[i] = (i_avg >= (LEVEL_BASE << i));
	end

	always_comb begin
		s_next = s_reg;
		s_next.level = lit;
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign o_level = s_reg.level;
endmodule : level_mapper
`default_nettype wire

// ==== src/i2c_sensor_poller.sv ====
// i2c sensor poller: humidity/temperature, power monitor and
// proximity readers sharing one i2c master, plus conversions.
// assumes the three sensors share one open-drain bus; pins and
// the ready line are synchronous to i_clock.
`default_nettype none
module i2c_sensor_poller
	import i2c_poller_pkg::*;
(
	// clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rstn,
	// i2c bus, open drain: oe high pulls the line low
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	output logic             o_scl,
	output logic             o_scl_oe,
	output logic             o_sda,
	output logic             o_sda_oe,
	// humidity sensor ready line, active low
	input  wire logic        i_sensor_result_ready_n,
	// humidity/temperature results
	output logic [15:0]      o_temp_raw,
	output logic [15:0]      o_humidity_raw,
	output logic [8:0]       o_temp_celsius,
	// power monitor results
	output logic [15:0]      o_bus_raw,
	output logic [15:0]      o_shunt_raw,
	output logic [15:0]      o_current_raw,
	output logic [15:0]      o_power_raw,
	output logic [31:0]      o_bus_uv,
	output logic [31:0]      o_shunt_nv,
	output logic [31:0]      o_power_uw,
	output logic [31:0]      o_current_calc_ua,
	output logic [31:0]      o_power_calc_uw,
	// proximity results
	output logic [15:0]      o_proximity_channel_one,
	output logic [15:0]      o_proximity_channel_two,
	output logic [15:0]      o_proximity_channel_three,
	output logic [15:0]      o_proximity_avg,
	output logic [7:0]       o_level,
	// status
	output logic             o_cal_done,
	output logic             o_loop_done,
	output logic             o_nack_seen
);
	typedef enum logic [4:0] {
		S_CAL_START, S_CAL_ADDR, S_CAL_REG, S_CAL_HI, S_CAL_LO,
		S_CAL_STOP, S_P_START, S_P_ADDR, S_P_REG, S_P_STOP,
		S_WAIT_RDY, S_R_START, S_R_ADDR, S_R_HI, S_R_LO,
		S_R_STOP, S_STORE
	} seq_t;

	typedef struct packed {
		seq_t            st;        // sequencer state
		logic            pend;      // engine command outstanding
		logic [3:0]      slot;      // schedule index
		logic            seen_high; // ready line went high
		logic [15:0]     data;      // bytes shifted in
		logic            cal_done;  // calibration written
		logic            loop_done; // schedule wrapped, pulse
		logic            nack_acc;  // nack in current loop
		logic            nack_seen; // nack in last loop
		logic [15:0]     temp;
		logic [15:0]     hum;
		logic [15:0]     bus;
		logic [15:0]     shunt;
		logic [15:0]     cur;
		logic [15:0]     pwr;
		logic [2:0][15:0] prox;
		logic [8:0]      celsius;
		logic [31:0]     bus_uv;
		logic [31:0]     shunt_nv;
		logic [31:0]     power_uw;
		logic [31:0]     cur_ua;
		logic [31:0]     pcalc_uw;
		logic [15:0]     avg;
	} top_t;
	top_t s_reg, s_next;

	// engine handshake
	logic            cmd_valid;
	i2c_cmd_t        cmd;
	logic [7:0]      wdata;
	logic            master_ack;
	logic            eng_done;
	logic            eng_nack;
	logic [7:0]      eng_rdata;
	slot_t           cur_slot;   // decoded schedule entry
	// conversion intermediates
	logic [23:0]     temp_prod;
	logic [31:0]     bus_prod;
	logic signed [31:0] shunt_prod;
	logic signed [31:0] cur_q;
	logic signed [63:0] pw_prod;
	logic [17:0]     prox_sum;
	logic [1:0]      ch;

	assign cur_slot = slot_info(s_reg.slot);

	// command chosen by state; one engine serves all three readers
	always_comb begin
		cmd        = CMD_START;
		wdata      = 8'h00;
		master_ack = 1'b0;
		cmd_valid  = 1'b1;
		unique case (s_reg.st)
			S_CAL_START, S_P_START, S_R_START: cmd = CMD_START;
			S_CAL_ADDR: begin
				cmd   = CMD_WRITE;
				wdata = POWER_ADDR;
			end
			S_CAL_REG: begin
				cmd   = CMD_WRITE;
				wdata = PM_CAL_REG;
			end
			S_CAL_HI: begin
				cmd   = CMD_WRITE;
				wdata = CAL_VALUE[15:8];
			end
			S_CAL_LO: begin
				cmd   = CMD_WRITE;
				wdata = CAL_VALUE[7:0];
			end
			S_P_ADDR: begin
				// addresses per sensor come from the schedule
				cmd   = CMD_WRITE;
				wdata = cur_slot.dev;
			end
			S_P_REG: begin
				// pointer write opens every measurement cycle
				cmd   = CMD_WRITE;
				wdata = cur_slot.ptr;
			end
			S_R_ADDR: begin
				cmd   = CMD_WRITE;
				wdata = cur_slot.dev | RD_BIT;
			end
			S_R_HI: begin
				// ack only when a second byte follows
				cmd        = CMD_READ;
				master_ack = cur_slot.two_byte;
			end
			S_R_LO: cmd = CMD_READ;
			S_CAL_STOP, S_P_STOP, S_R_STOP: cmd = CMD_STOP;
			S_WAIT_RDY, S_STORE: cmd_valid = 1'b0;
		endcase
		// only one command outstanding at a time
		if (s_reg.pend)
			cmd_valid = 1'b0;
	end

	// conversions from the stored raw words; operands widened first
	always_comb begin
		temp_prod  = 24'(s_reg.temp) * 24'(TEMP_SPAN);
		bus_prod   = 32'(s_reg.bus) * 32'(BUS_UV_PER_LSB);
		shunt_prod = $signed({{16{s_reg.shunt[15]}}, s_reg.shunt}) *
			$signed({16'h0000, SHUNT_NV_PER_LSB});
		// nV over milliohm gives uA
		cur_q = shunt_prod /
			$signed({28'h0, SHUNT_MILLIOHM});
		pw_prod = 64'($signed({32'h0, bus_prod}) * cur_q /
			$signed({44'h0, UW_PER_W_SCALE}));
		prox_sum = 18'(s_reg.prox[0]) + 18'(s_reg.prox[1]) +
			18'(s_reg.prox[2]);
	end

	// sequencer and result store
	always_comb begin
		s_next = s_reg;
		s_next.loop_done = 1'b0;
		ch = 2'((s_reg.slot - SLOT_PROX) >> 1);
		// conversions follow the raw words one cycle later
		s_next.celsius  = {1'b0, temp_prod[23:16]} - TEMP_OFFSET;
		s_next.bus_uv   = bus_prod;
		s_next.shunt_nv = shunt_prod;
		s_next.power_uw = 32'(s_reg.pwr) * 32'(POWER_UW_PER_LSB);
		s_next.cur_ua   = cur_q;
		s_next.pcalc_uw = pw_prod[31:0];
		s_next.avg      = 16'(prox_sum / 18'h3);
		if (cmd_valid)
			s_next.pend = 1'b1;
		if (eng_done) begin
			s_next.pend = 1'b0;
			// a nack on any write is reported once per loop
			if (cmd == CMD_WRITE && eng_nack)
				s_next.nack_acc = 1'b1;
		end
		unique case (s_reg.st)
			S_WAIT_RDY: begin
				// conversion started: wait for high, then low
				if (i_sensor_result_ready_n)
					s_next.seen_high = 1'b1;
				if (s_reg.seen_high && !i_sensor_result_ready_n)
					s_next.st = S_R_START;
			end
			S_STORE: begin
				// 16-bit words latched whole after the transfer; proximity bytes one half at a time
				unique case (s_reg.slot)
					4'h0: s_next.temp  = s_reg.data;
					4'h1: s_next.hum   = s_reg.data;
					4'h2: s_next.bus   = s_reg.data;
					4'h3: s_next.shunt = s_reg.data;
					4'h4: s_next.cur   = s_reg.data;
					4'h5: s_next.pwr   = s_reg.data;
					default: begin
						// even pointer is low byte, odd is high
						if (s_reg.slot[0])
							s_next.prox[ch][15:8] = s_reg.data[7:0];
						else
							s_next.prox[ch][7:0] = s_reg.data[7:0];
					end
				endcase
				// schedule never stops; wrap to the first slot
				if (s_reg.slot == SLOT_LAST) begin
					s_next.slot      = '0;
					s_next.loop_done = 1'b1;
					s_next.nack_seen = s_reg.nack_acc;
					s_next.nack_acc  = 1'b0;
				end else begin
					s_next.slot = s_reg.slot + 4'h1;
				end
				s_next.st = S_P_START;
			end
			default: begin
				if (eng_done) begin
					unique case (s_reg.st)
						S_CAL_START: s_next.st = S_CAL_ADDR;
						S_CAL_ADDR:  s_next.st = S_CAL_REG;
						S_CAL_REG:   s_next.st = S_CAL_HI;
						S_CAL_HI:    s_next.st = S_CAL_LO;
						S_CAL_LO:    s_next.st = S_CAL_STOP;
						S_CAL_STOP: begin
							s_next.cal_done = 1'b1;
							s_next.st = S_P_START;
						end
						S_P_START: s_next.st = S_P_ADDR;
						S_P_ADDR:  s_next.st = S_P_REG;
						S_P_REG: begin
							// humidity sensor converts after the
							// pointer, others go straight to read
							s_next.st = cur_slot.wait_rdy ? S_P_STOP
								: S_R_START;
						end
						S_P_STOP: begin
							s_next.seen_high = 1'b0;
							s_next.st = S_WAIT_RDY;
						end
						S_R_START: s_next.st = S_R_ADDR;
						// read phase has no path back to a pointer
						S_R_ADDR:  s_next.st = S_R_HI;
						S_R_HI: begin
							s_next.data = {s_reg.data[7:0], eng_rdata};
							s_next.st = cur_slot.two_byte ? S_R_LO
								: S_R_STOP;
						end
						S_R_LO: begin
							s_next.data = {s_reg.data[7:0], eng_rdata};
							s_next.st = S_R_STOP;
						end
						S_R_STOP: s_next.st = S_STORE;
						default: ;
					endcase
				end
			end
		endcase
	end

	// state register; reset begins with the calibration write
	always_ff @(posedge i_clock) begin
		if (!i_rstn)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	// shared byte engine
	i2c_byte_engine u_engine (
		.i_clock      (i_clock),
		.i_rstn       (i_rstn),
		.i_cmd_valid  (cmd_valid),
		.i_cmd        (cmd),
		.i_wdata      (wdata),
		.i_master_ack (master_ack),
		.o_done       (eng_done),
		.o_nack       (eng_nack),
		.o_rdata      (eng_rdata),
		.i_scl        (i_scl),
		.i_sda        (i_sda),
		.o_scl_oe     (o_scl_oe),
		.o_sda_oe     (o_sda_oe)
	);

	// indicator bar
	level_mapper u_mapper (
		.i_clock (i_clock),
		.i_rstn  (i_rstn),
		.i_avg   (s_reg.avg),
		.o_level (o_level)
	);

	// open drain: the driven level is always low
	assign o_scl = 1'b0;
	assign o_sda = 1'b0;
	assign o_temp_raw                = s_reg.temp;
	assign o_humidity_raw            = s_reg.hum;
	assign o_temp_celsius            = s_reg.celsius;
	assign o_bus_raw                 = s_reg.bus;
	assign o_shunt_raw               = s_reg.shunt;
	assign o_current_raw             = s_reg.cur;
	assign o_power_raw               = s_reg.pwr;
	assign o_bus_uv                  = s_reg.bus_uv;
	assign o_shunt_nv                = s_reg.shunt_nv;
	assign o_power_uw                = s_reg.power_uw;
	assign o_current_calc_ua         = s_reg.cur_ua;
	assign o_power_calc_uw           = s_reg.pcalc_uw;
	assign o_proximity_channel_one   = s_reg.prox[0];
	assign o_proximity_channel_two   = s_reg.prox[1];
	assign o_proximity_channel_three = s_reg.prox[2];
	assign o_proximity_avg           = s_reg.avg;
	assign o_cal_done                = s_reg.cal_done;
	assign o_loop_done               = s_reg.loop_done;
	assign o_nack_seen               = s_reg.nack_seen;
endmodule : i2c_sensor_poller
`default_nettype wire

// ==== tb/i2c_poller_monitor.sv ====
// checker for the sensor poller: conversions, level bar, bus pace.
// assumes it is bound to the poller top and sees only its ports.
`default_nettype none
module i2c_poller_monitor
	import i2c_poller_pkg::*;
(
	input wire logic        i_clock,
	input wire logic        i_rstn,
	input wire logic        o_scl_oe,
	input wire logic [15:0] o_temp_raw,
	input wire logic [8:0]  o_temp_celsius,
	input wire logic [15:0] o_bus_raw,
	input wire logic [31:0] o_bus_uv,
	input wire logic [15:0] o_shunt_raw,
	input wire logic [31:0] o_shunt_nv,
	input wire logic [31:0] o_current_calc_ua,
	input wire logic [15:0] o_power_raw,
	input wire logic [31:0] o_power_uw,
	input wire logic [15:0] o_proximity_channel_one,
	input wire logic [15:0] o_proximity_channel_two,
	input wire logic [15:0] o_proximity_channel_three,
	input wire logic [15:0] o_proximity_avg,
	input wire logic [7:0]  o_level,
	input wire logic        o_cal_done
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	// last scl enable and clocks since it moved
	typedef struct packed {
		logic       scl_oe;
		logic [9:0] quiet;
	} pace_t;
	pace_t pace_reg;  // registered pace state
	pace_t pace_next; // next pace state
	// saturate so a long idle stretch never wraps to a small count
	always_comb begin
		pace_next = '{o_scl_oe, pace_reg.quiet + 10'h001};
		if (o_scl_oe != pace_reg.scl_oe) begin
			pace_next.quiet = 10'h000;
		end else if (pace_reg.quiet == 10'h3FF) begin
			pace_next.quiet = 10'h3FF;
		end
	end
	// pace register, cleared in reset
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			pace_reg <= '0;
		end else begin
			pace_reg <= pace_next;
		end
	end
	// expected bar: lowest always lit, bit i from 64 << i
	function automatic logic [7:0] bar_of(input logic [15:0] a);
		logic [7:0] b;
		b = 8'h01;
		for (int i = 1; i < 8; i++) begin
			b[i] = (a >= (16'h0040 << i));
		end
		return b;
	endfunction : bar_of
	scl_pace_a: assert property (
		$changed(o_scl_oe) |-> pace_reg.quiet >= 10'h3E7)
		else $error("scl moved sooner than two quarters");
	bar_map_a: assert property (
		$past(i_rstn) |-> o_level == bar_of($past(o_proximity_avg)))
		else $error("level bar does not match the average");
	bar_low_a: assert property ($past(i_rstn) |-> o_level[0])
		else $error("lowest indicator is dark");
	avg_a: assert property ($past(i_rstn) |-> o_proximity_avg ==
		16'((18'($past(o_proximity_channel_one))
		+ 18'($past(o_proximity_channel_two))
		+ 18'($past(o_proximity_channel_three))) / 18'h3))
		else $error("average of channels is wrong");
	celsius_a: assert property ($past(i_rstn) |-> o_temp_celsius ==
		9'(((32'($past(o_temp_raw)) * 32'hA5) >> 16) - 32'h28))
		else $error("celsius conversion is wrong");
	bus_uv_a: assert property ($past(i_rstn) |-> o_bus_uv ==
		32'($past(o_bus_raw)) * 32'h4E2)
		else $error("bus voltage scale is wrong");
	shunt_nv_a: assert property ($past(i_rstn) |-> o_shunt_nv ==
		32'($signed($past(o_shunt_raw)) * 32'sh9C4))
		else $error("shunt voltage scale is wrong");
	power_uw_a: assert property ($past(i_rstn) |-> o_power_uw ==
		32'($past(o_power_raw)) * 32'h9C4)
		else $error("power scale is wrong");
	current_a: assert property ($past(i_rstn) |->
		o_current_calc_ua == 32'($signed(o_shunt_nv) / 32'sh3))
		else $error("computed current is wrong");
	cal_hold_a: assert property (o_cal_done |=> o_cal_done)
		else $error("calibration flag dropped");
	cal_seen_c: cover property ($rose(o_cal_done));
	scl_move_c: cover property ($changed(o_scl_oe));
	bar_low_c: cover property (o_level == 8'h01);
endmodule : i2c_poller_monitor
bind i2c_sensor_poller i2c_poller_monitor u_monitor (.*);
`default_nettype wire

// ==== tb/sensor_bus_model.sv ====
// bus model of the sensors: acks address and written bytes, logs bytes.
// assumes resolved scl/sda levels, sampled on the system clock.
`default_nettype none
module sensor_bus_model (
	input  wire logic  i_clock,
	input  wire logic  i_scl,
	input  wire logic  i_sda,
	output logic       o_sda_oe,   // high pulls sda low
	output logic       o_start,    // start seen, one clock
	output logic       o_stop,     // stop seen, one clock
	output logic       o_byte_stb, // byte complete, one clock
	output logic [7:0] o_byte      // byte gathered so far, whole at o_byte_stb
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       scl_reg = 1'b1; // scl one clock ago
	logic       sda_reg = 1'b1; // sda one clock ago
	logic [3:0] bit_cnt = 4'h0; // bits of the current byte
	logic [7:0] shift = 8'h00;  // byte being gathered
	logic       first = 1'b0;   // next byte is an address byte
	logic       rd = 1'b0;      // read transfer: master owns the acks
	logic       ack_ok = 1'b0;  // current byte wants our ack
	initial {o_sda_oe, o_start, o_stop, o_byte_stb, o_byte} = '0;
	// outputs move by nonblocking update so the poller never races them
	always @(posedge i_clock) begin
		o_start <= i_scl && scl_reg && sda_reg && !i_sda;
		o_stop <= i_scl && scl_reg && !sda_reg && i_sda;
		o_byte_stb <= 1'b0;
		if (i_scl && scl_reg && sda_reg && !i_sda) begin
			bit_cnt = 4'h0; // start: a fresh byte follows
			first = 1'b1;
		end
		if (i_scl && !scl_reg) begin
			if (bit_cnt < 4'h8) begin // scl rose: data bit, msb first
				shift = {shift[6:0], i_sda};
				o_byte_stb <= (bit_cnt == 4'h7);
				o_byte <= shift;
				if (bit_cnt == 4'h7) begin
					// a read byte is acked by the master, not by us
					ack_ok = first || !rd;
					rd = first ? shift[0] : rd;
					first = 1'b0;
				end
			end
			bit_cnt = bit_cnt + 4'h1;
		end
		if (!i_scl && scl_reg) begin
			o_sda_oe <= (bit_cnt == 4'h8) && ack_ok;
			if (bit_cnt == 4'h9) begin
				bit_cnt = 4'h0; // released: line floats back high
			end
		end
		scl_reg = i_scl;
		sda_reg = i_sda;
	end
endmodule : sensor_bus_model
`default_nettype wire

// ==== tb/tb.sv ====
// testbench: calibration write, first pointer write, ready wait.
// assumes the poller top, its package, bus model and checker.
`default_nettype none
module tb import i2c_poller_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic       i_clock = 1'b0; // 200 MHz system clock
	logic       i_rstn = 1'b0;  // held low for two clocks
	logic       ready_n = 1'b0; // humidity ready line
	logic       scl_oe, sda_oe, model_oe, start_stb, stop_stb;
	logic       byte_stb, cal_done, nack;
	logic [7:0] rx_byte, level;
	wire logic  scl = ~scl_oe;             // pull-up on scl
	wire logic  sda = ~(sda_oe | model_oe); // pull-up on sda
	logic [7:0] log_q[$]; // bytes seen on the bus
	int         n_start = 0, n_stop = 0, n_fail = 0, compares = 0;
	always #2.5 i_clock = ~i_clock;
	i2c_sensor_poller uut (.i_clock(i_clock), .i_rstn(i_rstn),
		.i_scl(scl), .i_sda(sda), .o_scl(), .o_scl_oe(scl_oe), .o_sda(),
		.o_sda_oe(sda_oe), .i_sensor_result_ready_n(ready_n),
		.o_temp_raw(), .o_humidity_raw(), .o_temp_celsius(), .o_bus_raw(),
		.o_shunt_raw(), .o_current_raw(), .o_power_raw(), .o_bus_uv(),
		.o_shunt_nv(), .o_power_uw(), .o_current_calc_ua(),
		.o_power_calc_uw(), .o_proximity_channel_one(),
		.o_proximity_channel_two(), .o_proximity_channel_three(),
		.o_proximity_avg(), .o_level(level), .o_cal_done(cal_done),
		.o_loop_done(), .o_nack_seen(nack));
	sensor_bus_model partner (.i_clock(i_clock), .i_scl(scl),
		.i_sda(sda), .o_sda_oe(model_oe), .o_start(start_stb),
		.o_stop(stop_stb), .o_byte_stb(byte_stb), .o_byte(rx_byte));
	// collect what the bus model saw
	always @(posedge i_clock) begin
		if (byte_stb) begin
			log_q.push_back(rx_byte);
		end
		n_start += int'(start_stb);
		n_stop += int'(stop_stb);
	end
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// inputs change 1 ns after the rising edge
	task automatic step(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask : step
	task automatic reset_state();
		step(2);
		check("level after reset", 16'(level), 16'h0001);
		check("cal before write", 16'(cal_done), 16'h0000);
	endtask : reset_state
	task automatic calibration_write();
		logic [15:0] cal;
		int          i;
		cal = 16'($rtoi(0.00512 / (MAX_CURRENT_A / 32768.0 * 0.003)));
		i = 0;
		while (cal_done !== 1'b1 && i < 90000) begin
			step(1);
			i++;
		end
		check("cal done", 16'(cal_done), 16'h0001);
		check("cal bytes", 16'(log_q.size()), 16'h0004);
		check("cal address", 16'(log_q[0]), 16'h0080);
		check("cal pointer", 16'(log_q[1]), 16'(PM_CAL_REG));
		check("cal high", 16'(log_q[2]), 16'(cal[15:8]));
		check("cal low", 16'(log_q[3]), 16'(cal[7:0]));
	endtask : calibration_write
	task automatic pointer_write();
		int i;
		i = 0;
		while (n_stop < 2 && i < 50000) begin
			step(1);
			i++;
		end
		check("pointer stops", 16'(n_stop), 16'h0002);
		check("pointer bytes", 16'(log_q.size()), 16'h0006);
		check("humid address", 16'(log_q[4]), 16'h0080);
		check("temp pointer", 16'(log_q[5]), 16'h0000);
	endtask : pointer_write
	// read must wait for a high then low ready, with no new pointer
	task automatic ready_wait();
		int i;
		step(3000);
		check("idle while low", 16'(n_start), 16'h0002);
		ready_n = 1'b1;
		step(3000);
		check("idle while high", 16'(n_start), 16'h0002);
		ready_n = 1'b0;
		i = 0;
		while (n_start < 3 && i < 3000) begin
			step(1);
			i++;
		end
		check("read started", 16'(n_start), 16'h0003);
		check("no new pointer", 16'(log_q.size()), 16'h0006);
		check("no nack", 16'(nack), 16'h0000);
	endtask : ready_wait
	task automatic tally_and_finish();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		step(2);
		i_rstn = 1'b1;
		reset_state();
		calibration_write();
		pointer_write();
		ready_wait();
		tally_and_finish();
	end
	// the whole run needs about 125000 clocks
	initial begin
		repeat (140000) @(posedge i_clock);
		n_fail++;
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
